// *** hmp_pkg.sv ***
// Shared constants for the host memory access port and its host controller.
package hmp_pkg;
	// ********************************************************************
	// Device side
	// ********************************************************************
	localparam int AW = 14;
	localparam int CW_OVL_BIT = 15;
	localparam int CW_PROG_BIT = 14;
	localparam int SHORT_RD_BIT = 14;
	localparam logic [13:0] ADR_OVERLAY = 14'h3fe0;
	localparam logic [13:0] ADR_START = 14'h3fe1;
	localparam logic [13:0] ADR_SYSCTL = 14'h3fe7;
	localparam logic [15:0] OVERLAY_RST = 16'h0000;
	localparam logic [15:0] SYSCTL_RST = 16'h0000;
	localparam logic [2:0] BOOT_HOST_MODE = 3'h5;
	localparam logic [3:0] CTL_IDLE = 4'hb;
	// ********************************************************************
	// Host controller
	// ********************************************************************
	localparam logic [4:0] REG_ADDR = 5'h00;
	localparam logic [4:0] REG_WDATA = 5'h04;
	localparam logic [4:0] REG_RTRIG = 5'h08;
	localparam logic [4:0] REG_RDATA = 5'h0c;
	localparam logic [4:0] REG_STATUS = 5'h10;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int CLK_MHZ = 100;
	localparam int PHASE_NS = 40;
	localparam int GAP_NS = 50;
	localparam int PHASE_CYC = (PHASE_NS * CLK_MHZ + 999) / 1000;
	localparam int GAP_CYC = (GAP_NS * CLK_MHZ + 999) / 1000;
endpackage

// *** hmp_if.sv ***
// Pin bundle between the host controller and the memory access port.
`timescale 1ns/1ps
interface hmp_if;
	logic [15:0] host_ad_o;
	logic        host_ad_oe_n;
	logic [15:0] dev_ad_o;
	logic        dev_ad_oe_n;
	logic [15:0] ad;
	logic        host_select_n;
	logic        host_addr_latch;
	logic        host_read_strobe_n;
	logic        host_write_strobe_n;
	logic        host_ack_n;

	// The shared bus floats high when nobody drives it.
	assign ad = !host_ad_oe_n ? host_ad_o : (!dev_ad_oe_n ? dev_ad_o : 16'hffff);

	modport dev (input ad, host_select_n, host_addr_latch, host_read_strobe_n,
		host_write_strobe_n, output dev_ad_o, dev_ad_oe_n, host_ack_n);
	modport host (input ad, host_ack_n, output host_ad_o, host_ad_oe_n,
		host_select_n, host_addr_latch, host_read_strobe_n, host_write_strobe_n);
endinterface

// *** hmp_host.sv ***
// Host controller: drives the port pins on orders taken over AXI4-Lite.
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module hmp_host (
	input  wire logic        i_mclk,    // System clock
	input  wire logic        i_rst_n,   // Synchronous reset
	hmp_if.host              bus,       // Port pins
	input  wire logic        i_awvalid, // Write address valid
	output logic             o_awready, // Write address ready
	input  wire logic [4:0]  i_awaddr,  // Write address
	input  wire logic        i_wvalid,  // Write data valid
	output logic             o_wready,  // Write data ready
	input  wire logic [31:0] i_wdata,   // Write data
	output logic             o_bvalid,  // Write response valid
	input  wire logic        i_bready,  // Write response ready
	output logic [1:0]       o_bresp,   // Write response
	input  wire logic        i_arvalid, // Read address valid
	output logic             o_arready, // Read address ready
	input  wire logic [4:0]  i_araddr,  // Read address
	output logic             o_rvalid,  // Read data valid
	input  wire logic        i_rready,  // Read data ready
	output logic [31:0]      o_rdata,   // Read data
	output logic [1:0]       o_rresp    // Read response
);
	typedef enum {H_IDLE, H_CHK, H_ADDR, H_AFALL, H_STRB, H_GAP} hmp_hst_t;
	typedef enum {OP_ADDR, OP_WR, OP_RD} hmp_op_t;
	hmp_hst_t    st;
	hmp_op_t     op;
	logic [4:0]  aw_a;
	logic [15:0] w_d, word, rd_word;
	logic [1:0]  ack_q;
	logic [15:0] ad_q1, ad_q2;
	logic [2:0]  cnt;
	logic        seen_busy;
	logic        wr_go, start;

	// ********************************************************************
	// AXI4-Lite slave
	// ********************************************************************
	assign wr_go = !o_awready && !o_wready && !o_bvalid;
	assign start = wr_go && st == H_IDLE
		&& (aw_a == hmp_pkg::REG_ADDR || aw_a == hmp_pkg::REG_WDATA
		|| aw_a == hmp_pkg::REG_RTRIG);

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			o_awready <= 1'b1;
			o_wready <= 1'b1;
			o_bvalid <= 1'b0;
			o_bresp <= hmp_pkg::RESP_OKAY;
			aw_a <= 5'h00;
			w_d <= 16'h0000;
		end
		else
		begin
			if (i_awvalid && o_awready)
			begin
				o_awready <= 1'b0;
				aw_a <= i_awaddr;
			end
			if (i_wvalid && o_wready)
			begin
				o_wready <= 1'b0;
				w_d <= i_wdata[15:0];
			end
			if (wr_go)
			begin
				o_bvalid <= 1'b1;
				o_bresp <= (aw_a == hmp_pkg::REG_ADDR || aw_a == hmp_pkg::REG_WDATA
					|| aw_a == hmp_pkg::REG_RTRIG) ? hmp_pkg::RESP_OKAY
					: hmp_pkg::RESP_SLVERR;
			end
			if (o_bvalid && i_bready)
			begin
				o_bvalid <= 1'b0;
				o_awready <= 1'b1;
				o_wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			o_arready <= 1'b1;
			o_rvalid <= 1'b0;
			o_rdata <= 32'h0000_0000;
			o_rresp <= hmp_pkg::RESP_OKAY;
		end
		else if (i_arvalid && o_arready)
		begin
			o_arready <= 1'b0;
			o_rvalid <= 1'b1;
			o_rresp <= hmp_pkg::RESP_OKAY;
			case (i_araddr)
				hmp_pkg::REG_ADDR: o_rdata <= {16'h0000, word};
				hmp_pkg::REG_RDATA: o_rdata <= {16'h0000, rd_word};
				hmp_pkg::REG_STATUS: o_rdata <= {31'h0, st != H_IDLE};
				default:
				begin
					o_rdata <= 32'h0000_0000;
					o_rresp <= hmp_pkg::RESP_SLVERR;
				end
			endcase
		end
		else if (o_rvalid && i_rready)
		begin
			o_rvalid <= 1'b0;
			o_arready <= 1'b1;
		end
	end

	// ********************************************************************
	// Pin sequencer
	// ********************************************************************
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			ack_q <= 2'h3;
			ad_q1 <= 16'h0000;
			ad_q2 <= 16'h0000;
		end
		else
		begin
			ack_q <= {ack_q[0], bus.host_ack_n};
			ad_q1 <= bus.ad;
			ad_q2 <= ad_q1;
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			st <= H_IDLE;
			op <= OP_ADDR;
			word <= 16'h0000;
			rd_word <= 16'h0000;
			cnt <= 3'h0;
			seen_busy <= 1'b0;
			bus.host_ad_o <= 16'h0000;
			bus.host_ad_oe_n <= 1'b1;
			bus.host_select_n <= 1'b1;
			bus.host_addr_latch <= 1'b0;
			bus.host_read_strobe_n <= 1'b1;
			bus.host_write_strobe_n <= 1'b1;
		end
		else
		begin
			case (st)
				H_IDLE:
				if (start)
				begin
					st <= H_CHK;
					if (aw_a == hmp_pkg::REG_ADDR)
					begin
						op <= OP_ADDR;
						// Overlay words carry zeros in bits 14:8.
						word <= w_d[15] ? {8'h80, w_d[7:0]} : w_d;
					end
					else if (aw_a == hmp_pkg::REG_WDATA)
					begin
						op <= OP_WR;
						word <= w_d;
					end
					else
						op <= OP_RD;
				end
				H_CHK:
				if (!ack_q[1])
				begin
					cnt <= 3'h0;
					seen_busy <= 1'b0;
					bus.host_select_n <= 1'b0;
					bus.host_ad_o <= word;
					bus.host_ad_oe_n <= (op == OP_RD);
					bus.host_addr_latch <= (op == OP_ADDR);
					bus.host_write_strobe_n <= (op != OP_WR);
					bus.host_read_strobe_n <= (op != OP_RD);
					st <= (op == OP_ADDR) ? H_ADDR : H_STRB;
				end
				H_ADDR:
				begin
					cnt <= cnt + 3'h1;
					if (cnt == 3'(hmp_pkg::PHASE_CYC - 1))
					begin
						bus.host_addr_latch <= 1'b0;
						cnt <= 3'h0;
						st <= H_AFALL;
					end
				end
				H_AFALL:
				begin
					cnt <= cnt + 3'h1;
					if (cnt == 3'(hmp_pkg::PHASE_CYC - 1))
					begin
						bus.host_select_n <= 1'b1;
						bus.host_ad_oe_n <= 1'b1;
						cnt <= 3'h0;
						st <= H_GAP;
					end
				end
				H_STRB:
				begin
					if (ack_q[1])
						seen_busy <= 1'b1;
					if (seen_busy && !ack_q[1])
					begin
						if (op == OP_RD)
							rd_word <= ad_q2;
						bus.host_select_n <= 1'b1;
						bus.host_read_strobe_n <= 1'b1;
						bus.host_write_strobe_n <= 1'b1;
						bus.host_ad_oe_n <= 1'b1;
						cnt <= 3'h0;
						st <= H_GAP;
					end
				end
				H_GAP:
				begin
					cnt <= cnt + 3'h1;
					if (cnt == 3'(hmp_pkg::GAP_CYC - 1))
						st <= H_IDLE;
				end
				default: st <= H_IDLE;
			endcase
		end
	end
endmodule

// *** hmp_dev.sv ***
// Memory access port of the processor: host pins, memories, boot hold.
`timescale 1ns/1ps
module hmp_dev #(
	parameter int AW = hmp_pkg::AW
) (
	input  wire logic          i_mclk,         // System clock
	input  wire logic          i_rst_n,        // Synchronous reset
	hmp_if.dev                 bus,            // Port pins
	input  wire logic [2:0]    i_boot_mode,    // Mode pins C, B, A
	input  wire logic          i_core_we,      // Core data write
	input  wire logic [AW-1:0] i_core_addr,    // Core data address
	input  wire logic [15:0]   i_core_wdata,   // Core write data
	output logic [15:0]        o_core_rdata,   // Core read data
	input  wire logic [AW-1:0] i_core_prog_addr, // Core program fetch address
	output logic [23:0]        o_core_prog_data, // Core program fetch data
	output logic               o_core_run      // Core may execute
);
	typedef enum {S_IDLE, S_SYNC, S_ACCESS, S_EXTRA, S_DONE} hmp_dst_t;
	hmp_dst_t    st, next_st;
	logic [15:0] data_memory [2**AW];
	logic [23:0] program_memory [2**AW];
	logic [3:0]  ctl_q1, ctl_q2, ctl_q3;
	logic [15:0] ad_q1, ad_q2;
	logic [2:0]  mode_q1, mode_q2;
	logic [1:0]  boot_cnt;
	logic [15:0] host_start_address, overlay_select, sysctl;
	logic [15:0] rword, hold;
	logic [7:0]  low_byte;
	logic        half, is_wr, latch_evt, req, host_acc, prog_sel;
	logic [AW-1:0] addr;

	// ********************************************************************
	// Pin synchronisers
	// ********************************************************************
	// Pins are asynchronous to the core clock, so each passes two flops.
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			ctl_q1 <= hmp_pkg::CTL_IDLE;
			ctl_q2 <= hmp_pkg::CTL_IDLE;
			ctl_q3 <= hmp_pkg::CTL_IDLE;
			ad_q1 <= 16'h0000;
			ad_q2 <= 16'h0000;
			mode_q1 <= 3'h0;
			mode_q2 <= 3'h0;
		end
		else
		begin
			ctl_q1 <= {bus.host_select_n, bus.host_addr_latch,
				bus.host_read_strobe_n, bus.host_write_strobe_n};
			ctl_q2 <= ctl_q1;
			ctl_q3 <= ctl_q2;
			ad_q1 <= bus.ad;
			ad_q2 <= ad_q1;
			mode_q1 <= i_boot_mode;
			mode_q2 <= mode_q1;
		end
	end

	// A control word is taken on the latch fall, or on select rising while
	// latch is still high.
	assign latch_evt = (ctl_q3[2] && !ctl_q2[2] && !ctl_q2[3])
		|| (!ctl_q3[3] && ctl_q2[3] && ctl_q2[2]);
	assign req = !ctl_q2[3] && !ctl_q2[2] && (!ctl_q2[1] || !ctl_q2[0]);
	assign host_acc = (st == S_ACCESS);
	assign addr = host_start_address[AW-1:0];
	assign prog_sel = host_start_address[hmp_pkg::CW_PROG_BIT];

	// ********************************************************************
	// Transaction sequencer
	// ********************************************************************
	always_comb
	begin
		next_st = st;
		case (st)
			S_IDLE: if (req) next_st = S_SYNC;
			S_SYNC: next_st = S_ACCESS;
			S_ACCESS:
				next_st = (!is_wr && !sysctl[hmp_pkg::SHORT_RD_BIT]) ? S_EXTRA : S_DONE;
			S_EXTRA: next_st = S_DONE;
			S_DONE: if (!req) next_st = S_IDLE;
			default: next_st = S_IDLE;
		endcase
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			st <= S_IDLE;
			is_wr <= 1'b0;
			bus.host_ack_n <= 1'b1;
			bus.dev_ad_oe_n <= 1'b1;
		end
		else
		begin
			st <= next_st;
			if (st == S_IDLE && req)
				is_wr <= !ctl_q2[0];
			// Ready only when idle or finished, so a new request sees busy.
			bus.host_ack_n <= !(next_st == S_IDLE || next_st == S_DONE);
			bus.dev_ad_oe_n <= !(next_st == S_DONE && !is_wr);
		end
	end

	// ********************************************************************
	// Start address, overlay and control registers
	// ********************************************************************
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			host_start_address <= 16'h0000;
			half <= 1'b0;
		end
		else if (latch_evt && !ad_q2[hmp_pkg::CW_OVL_BIT])
		begin
			host_start_address <= {1'b0, ad_q2[14:0]};
			half <= 1'b0;
		end
		else if (i_core_we && i_core_addr == hmp_pkg::ADR_START)
		begin
			host_start_address <= i_core_wdata;
			half <= 1'b0;
		end
		else if (host_acc)
		begin
			// Program words take two transfers; address steps after the second.
			if (prog_sel && !half)
				half <= 1'b1;
			else
			begin
				half <= 1'b0;
				host_start_address[AW-1:0] <= addr + 1'b1;
			end
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
			overlay_select <= hmp_pkg::OVERLAY_RST;
		else if (latch_evt && ad_q2[hmp_pkg::CW_OVL_BIT])
			overlay_select <= {8'h00, ad_q2[7:0]};
		else if (i_core_we && i_core_addr == hmp_pkg::ADR_OVERLAY)
			overlay_select <= i_core_wdata;
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
			sysctl <= hmp_pkg::SYSCTL_RST;
		else if (i_core_we && i_core_addr == hmp_pkg::ADR_SYSCTL)
			sysctl <= i_core_wdata;
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
			o_core_rdata <= 16'h0000;
		else
			case (i_core_addr)
				hmp_pkg::ADR_OVERLAY: o_core_rdata <= overlay_select;
				hmp_pkg::ADR_START: o_core_rdata <= host_start_address;
				hmp_pkg::ADR_SYSCTL: o_core_rdata <= sysctl;
				default: o_core_rdata <= data_memory[i_core_addr];
			endcase
	end

	// ********************************************************************
	// Memories
	// ********************************************************************
	// Host and core writes share one process; at equal addresses the core
	// write lands last, which is the cheapest ordering to document.
	always_ff @(posedge i_mclk)
	begin
		if (host_acc && is_wr && !prog_sel && addr < hmp_pkg::ADR_OVERLAY)
			data_memory[addr] <= ad_q2;
		if (i_core_we && i_core_addr < hmp_pkg::ADR_OVERLAY)
			data_memory[i_core_addr] <= i_core_wdata;
	end

	always_ff @(posedge i_mclk)
	begin
		if (host_acc && is_wr && prog_sel && half)
			program_memory[addr] <= {hold, ad_q2[7:0]};
		o_core_prog_data <= program_memory[i_core_prog_addr];
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			hold <= 16'h0000;
			low_byte <= 8'h00;
			rword <= 16'h0000;
		end
		else if (host_acc)
		begin
			if (is_wr)
				hold <= ad_q2;
			else if (prog_sel && !half)
			begin
				rword <= program_memory[addr][23:8];
				low_byte <= program_memory[addr][7:0];
			end
			else if (prog_sel)
				rword <= {8'h00, low_byte};
			// The start address is never a read source for the host.
			else if (addr == hmp_pkg::ADR_OVERLAY)
				rword <= overlay_select;
			else if (addr == hmp_pkg::ADR_SYSCTL)
				rword <= sysctl;
			else
				rword <= data_memory[addr];
		end
	end
	assign bus.dev_ad_o = rword;

	// ********************************************************************
	// Boot hold
	// ********************************************************************
	// Mode pins are read once, after they have settled through the
	// synchroniser following reset release.
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			boot_cnt <= 2'h0;
			o_core_run <= 1'b0;
		end
		else if (boot_cnt != 2'h3)
		begin
			boot_cnt <= boot_cnt + 2'h1;
			if (boot_cnt == 2'h2)
				o_core_run <= (mode_q2 != hmp_pkg::BOOT_HOST_MODE);
		end
		else if (host_acc && is_wr && prog_sel && half && addr == '0)
			o_core_run <= 1'b1;
	end
endmodule

// *** hmp_checker.sv ***
// Concurrent checks on the pins between the host controller and the memory access port.
`timescale 1ns/1ps
module hmp_checker (
	input wire logic i_mclk,              // System clock
	input wire logic i_rst_n,             // Synchronous reset
	input wire logic host_ad_oe_n,        // Host drives the bus when low
	input wire logic dev_ad_oe_n,         // Device drives the bus when low
	input wire logic host_select_n,       // Port select
	input wire logic host_addr_latch,     // Address latch
	input wire logic host_read_strobe_n,  // Read strobe
	input wire logic host_write_strobe_n, // Write strobe
	input wire logic host_ack_n           // Acknowledge, low when ready
);
	// ********************************************************************
	// Helpers
	// ********************************************************************
	logic strobes_n;
	assign strobes_n = host_read_strobe_n & host_write_strobe_n;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	// ********************************************************************
	// Assertions
	// ********************************************************************
	a_req_makes_busy: assert property (!host_select_n && $fell(strobes_n) |-> ##[2:5] host_ack_n)
		else $error("acknowledge stayed ready after a request");
	a_busy_length: assert property ($rose(host_ack_n) |=> host_ack_n ##[1:2] !host_ack_n)
		else $error("busy period has the wrong length");
	a_busy_qualified: assert property ($rose(host_ack_n) |-> !host_select_n && !strobes_n)
		else $error("busy without select and strobe");
	a_data_with_ack: assert property ($fell(dev_ad_oe_n) |-> $fell(host_ack_n) && !host_read_strobe_n)
		else $error("read data not driven with the ready edge");
	a_drive_when_ready: assert property (!dev_ad_oe_n |-> !host_ack_n && host_write_strobe_n)
		else $error("device drives the bus at a wrong time");
	a_one_driver: assert property (host_ad_oe_n || dev_ad_oe_n)
		else $error("both ends drive the bus");
	a_bus_released: assert property (!dev_ad_oe_n && host_read_strobe_n |-> ##[1:4] dev_ad_oe_n)
		else $error("device kept the bus after the strobe ended");
	a_strobe_on_ready: assert property ($fell(strobes_n) |-> !host_ack_n)
		else $error("host strobed while the device was busy");
	a_strobe_held: assert property ($rose(host_ack_n) |-> !strobes_n [*3])
		else $error("host released the strobe too early");
	a_latch_phase: assert property ($rose(host_addr_latch) |->
		(!host_select_n && host_addr_latch && !host_ack_n) [*4] ##1 (!host_select_n && !host_addr_latch))
		else $error("address phase malformed");
	// ********************************************************************
	// Coverage
	// ********************************************************************
	c_read: cover property ($fell(dev_ad_oe_n));
	c_long_busy: cover property ($rose(host_ack_n) ##3 !host_ack_n);
	c_latch: cover property ($fell(host_addr_latch));
endmodule

// *** hmp_tb_top.sv ***
// Self-checking bench: host controller and memory access port joined by their pins.
`timescale 1ns/1ps
module hmp_tb_top;
	typedef struct packed {
		logic [15:0] ctl;
		logic [15:0] dat;
	} hmp_row_t;
	logic        i_mclk, i_rst_n, awvalid, wvalid, bready, arvalid, rready, core_we;
	logic        awready, wready, bvalid, arready, rvalid, core_run;
	logic [4:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [1:0]  bresp, rresp, resp;
	logic [2:0]  boot_mode;
	logic [13:0] core_addr, prog_addr;
	logic [15:0] core_wdata, core_rdata, got;
	logic [23:0] prog_data, prog_got;
	int          n_mismatch = 0, checks_done = 0, run_len = 0, last_busy = 0;
	hmp_row_t    rows [3];
	hmp_if       hif ();
	hmp_host hmp_host_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .bus(hif), .i_awvalid(awvalid),
		.o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready),
		.i_wdata(wdata), .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
		.i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid),
		.i_rready(rready), .o_rdata(rdata), .o_rresp(rresp));
	hmp_dev hmp_dev_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .bus(hif), .i_boot_mode(boot_mode),
		.i_core_we(core_we), .i_core_addr(core_addr), .i_core_wdata(core_wdata),
		.o_core_rdata(core_rdata), .i_core_prog_addr(prog_addr), .o_core_prog_data(prog_data),
		.o_core_run(core_run));
	hmp_checker hmp_checker_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
		.host_ad_oe_n(hif.host_ad_oe_n), .dev_ad_oe_n(hif.dev_ad_oe_n),
		.host_select_n(hif.host_select_n), .host_addr_latch(hif.host_addr_latch),
		.host_read_strobe_n(hif.host_read_strobe_n),
		.host_write_strobe_n(hif.host_write_strobe_n), .host_ack_n(hif.host_ack_n));
	initial
	begin
		i_mclk = 1'b0;
		forever #5 i_mclk = ~i_mclk;
	end
	// Length of the last busy period, so transfer timing is measured at the pins.
	always @(posedge i_mclk)
	begin
		if (hif.host_ack_n === 1'b1)
			run_len <= run_len + 1;
		else if (run_len != 0)
		begin
			last_busy <= run_len;
			run_len <= 0;
		end
	end
	// ********************************************************************
	// Tasks
	// ********************************************************************
	task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("Error at %0t: got %h, expected %h", $time, g, e);
		end
	endtask
	task automatic chk_flag(input logic g, input logic e);
		chk_val({31'h0, g}, {31'h0, e});
	endtask
	task automatic tdone(input string s);
		$display("test %s done", s);
	endtask
	task automatic axi_wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge i_mclk);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= {16'h0000, d};
		bready <= 1'b1;
		do
		begin
			@(posedge i_mclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [4:0] a);
		@(posedge i_mclk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		do
		begin
			@(posedge i_mclk);
			if (arready)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
		rd = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask
	// Busy commands are silently dropped, so every order waits for the idle status.
	task automatic wait_idle();
		do
			axi_rd(hmp_pkg::REG_STATUS);
		while (rd[0] !== 1'b0);
	endtask
	task automatic cmd(input logic [4:0] a, input logic [15:0] d);
		wait_idle();
		axi_wr(a, d);
		chk_val({30'h0, resp}, {30'h0, hmp_pkg::RESP_OKAY});
	endtask
	task automatic prd();
		cmd(hmp_pkg::REG_RTRIG, 16'h0000);
		wait_idle();
		axi_rd(hmp_pkg::REG_RDATA);
		got = rd[15:0];
	endtask
	task automatic core_rd(input logic [13:0] a);
		@(posedge i_mclk);
		core_addr <= a;
		prog_addr <= a;
		repeat (2) @(posedge i_mclk);
		got = core_rdata;
		prog_got = prog_data;
	endtask
	task automatic core_wr(input logic [13:0] a, input logic [15:0] d);
		@(posedge i_mclk);
		core_we <= 1'b1;
		core_addr <= a;
		core_wdata <= d;
		@(posedge i_mclk);
		core_we <= 1'b0;
	endtask
	task automatic do_reset(input logic [2:0] mode);
		@(posedge i_mclk);
		i_rst_n <= 1'b0;
		boot_mode <= mode;
		repeat (8) @(posedge i_mclk);
		chk_flag(hif.host_ack_n, 1'b1);
		chk_flag(core_run, 1'b0);
		i_rst_n <= 1'b1;
		repeat (5) @(posedge i_mclk);
		chk_flag(hif.host_ack_n, 1'b0);
	endtask
	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ********************************************************************
	// Tests
	// ********************************************************************
	initial
	begin
		{i_rst_n, awvalid, wvalid, bready, arvalid, rready, core_we} = '0;
		{awaddr, araddr, core_addr, prog_addr, wdata, core_wdata, boot_mode} = '0;
		rows[0] = '{16'h0005, 16'ha5c3};
		rows[1] = '{16'h0123, 16'h5a3c};
		rows[2] = '{16'h1ffe, 16'hfffe};
		do_reset(hmp_pkg::BOOT_HOST_MODE);
		core_rd(hmp_pkg::ADR_OVERLAY);
		chk_val({16'h0, got}, {16'h0, hmp_pkg::OVERLAY_RST});
		core_rd(hmp_pkg::ADR_SYSCTL);
		chk_val({16'h0, got}, {16'h0, hmp_pkg::SYSCTL_RST});
		tdone("reset");
		foreach (rows[i])
		begin
			cmd(hmp_pkg::REG_ADDR, rows[i].ctl);
			cmd(hmp_pkg::REG_WDATA, rows[i].dat);
			wait_idle();
			chk_val(last_busy, 2);
			cmd(hmp_pkg::REG_ADDR, rows[i].ctl);
			prd();
			chk_val({16'h0, got}, {16'h0, rows[i].dat});
			chk_val(last_busy, 3);
			core_rd(rows[i].ctl[13:0]);
			chk_val({16'h0, got}, {16'h0, rows[i].dat});
		end
		tdone("rows");
		cmd(hmp_pkg::REG_ADDR, 16'h0040);
		for (int k = 0; k < 3; k++)
			cmd(hmp_pkg::REG_WDATA, 16'h1100 + 16'(k));
		for (int k = 0; k < 3; k++)
		begin
			core_rd(14'h0040 + 14'(k));
			chk_val({16'h0, got}, {16'h0, 16'h1100 + 16'(k)});
		end
		tdone("increment");
		cmd(hmp_pkg::REG_ADDR, 16'h4000);
		cmd(hmp_pkg::REG_WDATA, 16'h1234);
		wait_idle();
		chk_flag(core_run, 1'b0);
		cmd(hmp_pkg::REG_WDATA, 16'h0056);
		cmd(hmp_pkg::REG_WDATA, 16'habcd);
		cmd(hmp_pkg::REG_WDATA, 16'h00ef);
		wait_idle();
		chk_flag(core_run, 1'b1);
		core_rd(14'h0000);
		chk_val({8'h00, prog_got}, 32'h00123456);
		core_rd(14'h0001);
		chk_val({8'h00, prog_got}, 32'h00abcdef);
		cmd(hmp_pkg::REG_ADDR, 16'h4000);
		prd();
		chk_val({16'h0, got}, 32'h00001234);
		prd();
		chk_val({16'h0, got}, 32'h00000056);
		tdone("program words");
		core_wr(hmp_pkg::ADR_SYSCTL, 16'h4000);
		cmd(hmp_pkg::REG_ADDR, rows[0].ctl);
		prd();
		chk_val({16'h0, got}, {16'h0, rows[0].dat});
		chk_val(last_busy, 2);
		core_wr(hmp_pkg::ADR_START, rows[0].ctl);
		prd();
		chk_val({16'h0, got}, {16'h0, rows[0].dat});
		tdone("short read");
		cmd(hmp_pkg::REG_ADDR, 16'h3fe0);
		cmd(hmp_pkg::REG_WDATA, 16'h00ff);
		wait_idle();
		core_rd(hmp_pkg::ADR_OVERLAY);
		chk_val({16'h0, got}, {16'h0, hmp_pkg::OVERLAY_RST});
		cmd(hmp_pkg::REG_ADDR, 16'h8012);
		wait_idle();
		core_rd(hmp_pkg::ADR_OVERLAY);
		chk_val({16'h0, got}, 32'h00000012);
		cmd(hmp_pkg::REG_ADDR, 16'h8000);
		wait_idle();
		core_rd(hmp_pkg::ADR_OVERLAY);
		chk_val({16'h0, got}, 32'h00000000);
		tdone("overlay");
		axi_wr(5'h14, 16'h0001);
		chk_val({30'h0, resp}, {30'h0, hmp_pkg::RESP_SLVERR});
		axi_rd(5'h14);
		chk_val({30'h0, resp}, {30'h0, hmp_pkg::RESP_SLVERR});
		chk_val(rd, 32'h00000000);
		tdone("unmapped");
		do_reset(3'h0);
		chk_flag(core_run, 1'b1);
		cmd(hmp_pkg::REG_ADDR, rows[1].ctl);
		prd();
		chk_val({16'h0, got}, {16'h0, rows[1].dat});
		chk_val(last_busy, 3);
		tdone("second reset");
		end_of_test();
	end
	// The whole run needs roughly a thousand cycles; this limit only catches a hang.
	initial
	begin
		repeat (40000) @(posedge i_mclk);
		n_mismatch++;
		$display("Error at %0t: watchdog expired", $time);
		end_of_test();
	end
endmodule
